// >>> dmart_pkg.sv
// Purpose: Shared constants and types for the DMA channel request timing block
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers
// Notes:   Control fields sit at their documented bit positions
package dmart_pkg;

  // Register byte offsets
  localparam logic [3:0] DMART_CTRL_OFF   = 4'h0;
  localparam logic [3:0] DMART_STAT_OFF   = 4'h4;
  localparam logic [3:0] DMART_MASK_OFF   = 4'h8;
  localparam logic [3:0] DMART_WAIT_OFF   = 4'hc;

  // Control field positions
  localparam int DMART_SRC_BIT  = 16;
  localparam int DMART_TIME_LSB = 13;
  localparam int DMART_EIE_BIT  = 12;
  localparam int DMART_ACT_BIT  = 8;

  // Status bit positions
  localparam int DMART_STALL_BIT = 0;
  localparam int DMART_ERR_BIT   = 1;

  // Reset values
  localparam logic [31:0] DMART_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0]  DMART_STAT_RST = 2'h0;
  localparam logic [1:0]  DMART_MASK_RST = 2'h0;

  // Stall interval unit and counter width
  localparam int DMART_STALL_UNIT = 64;
  localparam int DMART_CNT_W      = 23;

  // Re-request delay base, doubled per code step
  localparam int DMART_DELAY_BASE = 16;

  typedef struct packed {
    logic       requestSourceSelect;
    logic [2:0] stallInterval;
    logic       errorIrqEnable;
    logic       active;
  } dmart_ctrl_s;

  typedef enum logic [2:0] {
    DMART_IDLE = 3'b001,
    DMART_OWN  = 3'b010,
    DMART_GAP  = 3'b100
  } dmart_state_e;

endpackage

// >>> dmart_channel.sv
// Purpose: DMA channel bus request timing, stall detection and error interrupt
// Assumes: ioRequest already synchronised to refClk polarity; arbiter on same clock
// Notes:   Registers over Wishbone classic, one-cycle ack after strobe
//
// What this block does
// - Source select 1: request bus while the I/O device raises its request.
// - Source select 0: request bus when wait countdown reaches zero.
// - I/O mode: count clocks without ownership after release; over limit sets stall.
// - Stall code 000 off; 001..111 give 960 up to 4194240 clocks.
// - Memory mode: wait programmed delay after release before next request.
// - Memory mode code 000: request continuously while active, release after operation.
// - Delay code 001 gives 16 clocks, 010 gives 32 clocks.
// - Error enable set: error end or stall flag raises interrupt when its mask bit is set; clear: none.
// - After reset source select, error enable and interval field read zero.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module dmart_channel
  import dmart_pkg::*;
#(
  // Counter width, must hold the longest stall interval
  parameter int CNT_W = DMART_CNT_W
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // I/O device and arbiter
  input  wire logic        ioRequest,
  input  wire logic        busGrant,
  input  wire logic        opDone,
  input  wire logic        errorEnd,
  output logic             busRequest,
  // Interrupt
  output logic             errorIrq
);

  dmart_ctrl_s         ctrl;
  dmart_ctrl_s         next_ctrl;
  logic [1:0]          status;
  logic [1:0]          next_status;
  logic [1:0]          mask;
  logic [1:0]          next_mask;
  logic [15:0]         waitCountdown;
  logic [15:0]         next_waitCountdown;
  logic [31:0]         rdData;
  logic [31:0]         next_rdData;
  logic                ack;
  logic                next_ack;
  dmart_state_e        state;
  dmart_state_e        next_state;
  logic [CNT_W-1:0]    count;
  logic [CNT_W-1:0]    next_count;
  logic [CNT_W-1:0]    stallLimit;
  logic [CNT_W-1:0]    gapLimit;
  logic                wbAccess;
  logic                wbWrite;
  logic                stallEvent;
  logic                wantBus;

  // Narrower counter would wrap before the longest interval
  if (CNT_W < DMART_CNT_W) begin : g_cnt_chk
    $error("dmart_channel: CNT_W too narrow for the longest stall interval");
  end

  assign wbAccess = wb_cyc_i && wb_stb_i && !ack;
  assign wbWrite  = wbAccess && wb_we_i;

  // Stall interval decode: (2^(2k+2)-1)*64 clocks
  always_comb begin
    case (ctrl.stallInterval)
      3'h1:    stallLimit = CNT_W'(15 * DMART_STALL_UNIT);
      3'h2:    stallLimit = CNT_W'(63 * DMART_STALL_UNIT);
      3'h3:    stallLimit = CNT_W'(255 * DMART_STALL_UNIT);
      3'h4:    stallLimit = CNT_W'(1023 * DMART_STALL_UNIT);
      3'h5:    stallLimit = CNT_W'(4095 * DMART_STALL_UNIT);
      3'h6:    stallLimit = CNT_W'(16383 * DMART_STALL_UNIT);
      3'h7:    stallLimit = CNT_W'(65535 * DMART_STALL_UNIT);
      default: stallLimit = '0;
    endcase
  end

  // Delay decode: 16 doubled per step
  always_comb begin
    if (ctrl.stallInterval == 3'h0) begin
      gapLimit = '0;
    end else begin
      gapLimit = CNT_W'(DMART_DELAY_BASE) << (ctrl.stallInterval - 3'h1);
    end
  end

  // Request source
  always_comb begin
    if (ctrl.requestSourceSelect) begin
      wantBus = ctrl.active && ioRequest;
    end else begin
      wantBus = ctrl.active && (waitCountdown == 16'h0000);
    end
  end

  // Ownership sequencing
  always_comb begin
    next_state = state;
    next_count = count;
    stallEvent = 1'b0;
    busRequest = 1'b0;
    case (state)
      DMART_IDLE: begin
        busRequest = wantBus;
        if (ctrl.requestSourceSelect && ctrl.active && stallLimit != '0) begin
          if (count > stallLimit) begin
            stallEvent = 1'b1;
            next_count = '0;
          end else begin
            next_count = count + 1'b1;
          end
        end
        if (busGrant && wantBus) begin
          next_state = DMART_OWN;
          next_count = '0;
        end
      end
      DMART_OWN: begin
        busRequest = 1'b1;
        if (opDone) begin
          next_count = '0;
          if (!ctrl.requestSourceSelect && gapLimit != '0) begin
            next_state = DMART_GAP;
          end else begin
            next_state = DMART_IDLE;
          end
        end
      end
      DMART_GAP: begin
        next_count = count + 1'b1;
        if (count + 1'b1 >= gapLimit) begin
          next_state = DMART_IDLE;
          next_count = '0;
        end
      end
      default: begin
        next_state = DMART_IDLE;
        next_count = '0;
      end
    endcase
    if (!ctrl.active) begin
      next_state = DMART_IDLE;
      next_count = '0;
    end
  end

  // Registers, status and countdown
  always_comb begin
    next_ctrl          = ctrl;
    next_mask          = mask;
    next_status        = status;
    next_waitCountdown = waitCountdown;
    next_ack           = wbAccess;
    next_rdData        = rdData;
    if (waitCountdown != 16'h0000) begin
      next_waitCountdown = waitCountdown - 16'h0001;
    end
    if (wbWrite) begin
      case (wb_adr_i)
        DMART_CTRL_OFF: begin
          if (wb_sel_i[2]) begin
            next_ctrl.requestSourceSelect = wb_dat_i[DMART_SRC_BIT];
          end
          if (wb_sel_i[1]) begin
            next_ctrl.stallInterval  = wb_dat_i[DMART_TIME_LSB+:3];
            next_ctrl.errorIrqEnable = wb_dat_i[DMART_EIE_BIT];
            next_ctrl.active         = wb_dat_i[DMART_ACT_BIT];
          end
        end
        DMART_STAT_OFF: begin
          if (wb_sel_i[0]) begin
            next_status = status & ~wb_dat_i[1:0];
          end
        end
        DMART_MASK_OFF: begin
          if (wb_sel_i[0]) begin
            next_mask = wb_dat_i[1:0];
          end
        end
        DMART_WAIT_OFF: begin
          if (wb_sel_i[0] && wb_sel_i[1]) begin
            next_waitCountdown = wb_dat_i[15:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear
    if (stallEvent) begin
      next_status[DMART_STALL_BIT] = 1'b1;
    end
    if (errorEnd) begin
      next_status[DMART_ERR_BIT] = 1'b1;
    end
    if (wbAccess && !wb_we_i) begin
      case (wb_adr_i)
        DMART_CTRL_OFF: begin
          next_rdData = '0;
          next_rdData[DMART_SRC_BIT]        = ctrl.requestSourceSelect;
          next_rdData[DMART_TIME_LSB+:3]    = ctrl.stallInterval;
          next_rdData[DMART_EIE_BIT]        = ctrl.errorIrqEnable;
          next_rdData[DMART_ACT_BIT]        = ctrl.active;
        end
        DMART_STAT_OFF: next_rdData = {30'h0, status};
        DMART_MASK_OFF: next_rdData = {30'h0, mask};
        DMART_WAIT_OFF: next_rdData = {16'h0, waitCountdown};
        default:        next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl          <= dmart_ctrl_s'(6'h00);
      status        <= DMART_STAT_RST;
      mask          <= DMART_MASK_RST;
      waitCountdown <= 16'h0000;
      rdData        <= 32'h0000_0000;
      ack           <= 1'b0;
      state         <= DMART_IDLE;
      count         <= '0;
    end else begin
      ctrl          <= next_ctrl;
      status        <= next_status;
      mask          <= next_mask;
      waitCountdown <= next_waitCountdown;
      rdData        <= next_rdData;
      ack           <= next_ack;
      state         <= next_state;
      count         <= next_count;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;
  // Error enable gates both flags onto the interrupt
  assign errorIrq = ctrl.errorIrqEnable && |(status & mask);

endmodule

// >>> dmart_chk.sv
// Purpose: Port checks for the channel request timing block
// Assumes: Full-word register writes
// Notes:   Shadows control, mask and ownership
`timescale 1ns/1ps
module dmart_chk
  import dmart_pkg::*;
(
  // Watched ports
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        ioRequest,
  input wire logic        busGrant,
  input wire logic        opDone,
  input wire logic        errorEnd,
  input wire logic        busRequest,
  input wire logic        errorIrq
);
  logic [31:0] ctl;
  logic [1:0]  msk;
  logic        own;
  wire         wr  = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  wire         mem = !ctl[16] & ctl[8];
  wire         gap = mem & own & opDone;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {ctl, msk, own} <= '0;
    end else begin
      if (wr && wb_adr_i == DMART_CTRL_OFF) ctl <= wb_dat_i;
      if (wr && wb_adr_i == DMART_MASK_OFF) msk <= wb_dat_i[1:0];
      own <= own ? !opDone : busRequest & busGrant;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_low8; !busRequest [*8]; endsequence
  sequence s_low16; s_low8 ##1 s_low8; endsequence
  AST_IO_REQ: assert property (ctl[16] && ctl[8] && !own && ioRequest |-> busRequest)
    else $error("io request lost");
  AST_IO_QUIET: assert property (ctl[16] && !own && !ioRequest |-> !busRequest)
    else $error("io request unasked");
  AST_GAP16: assert property (gap && ctl[15:13] == 3'h1 |=> s_low16 ##1 (busRequest || !mem))
    else $error("gap not 16");
  AST_GAP_MIN: assert property (gap && ctl[15:13] != 3'h0 |=> s_low8) else $error("gap short");
  AST_CONT: assert property (mem && own && ctl[15:13] == 3'h0 |-> busRequest)
    else $error("dropped while owning");
  AST_BACK: assert property (gap && ctl[15:13] == 3'h0 |=> busRequest || !mem)
    else $error("no re-request");
  AST_IRQ_OFF: assert property (!ctl[12] |-> !errorIrq) else $error("irq while off");
  AST_IRQ_ERR: assert property (errorEnd && ctl[12] && msk[1] |=> errorIrq)
    else $error("irq missing");
endmodule
bind dmart_channel dmart_chk i_dmart_chk (.*);

// >>> dmart_arb_model.sv
// Purpose: Arbiter model granting the channel and ending each operation
// Assumes: Grant comes grantLag cycles after a request
// Notes:   Ownership ends with a one-cycle done pulse
`timescale 1ns/1ps
module dmart_arb_model
  import dmart_pkg::*;
(
  // Channel side
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       busRequest,
  input  wire logic [3:0] grantLag,
  output logic            busGrant,
  output logic            opDone
);
  logic       own;
  logic [3:0] cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busGrant <= 1'h0;
      opDone   <= 1'h0;
      own      <= 1'h0;
      cnt      <= 4'h0;
    end else begin
      busGrant <= 1'h0;
      opDone   <= 1'h0;
      cnt      <= (busRequest || own) ? cnt + 4'h1 : 4'h0;
      if (own && cnt == 4'h3) begin
        opDone <= 1'h1;
        own    <= 1'h0;
        cnt    <= 4'h0;
      end else if (busGrant) begin
        own <= busRequest;
      end else if (busRequest && !own && cnt == grantLag) begin
        busGrant <= 1'h1;
        cnt      <= 4'h0;
      end
    end
  end
endmodule

// >>> dmart_channel_bench.sv
// Purpose: Self-checking bench for the channel request timing block
// Assumes: Arbiter model answers; bench drives io requests and errors
// Notes:   Stall checks use the shortest interval code
`timescale 1ns/1ps
module dmart_channel_bench
  import dmart_pkg::*;
;
  logic        ref_clk = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, ioRequest = 1'h0;
  logic        errorEnd = 1'h0, ack, busGrant, opDone, busRequest, errorIrq;
  logic [3:0]  adr = 4'h0, grantLag = 4'h0;
  logic [31:0] dati = 32'h0, dato, rd;
  int          badCount = 0, nCompared = 0;
  dmart_channel i_dmart_channel (.ref_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
    .ioRequest, .busGrant, .opDone, .errorEnd, .busRequest, .errorIrq);
  dmart_arb_model i_dmart_arb_model (.ref_clk, .rst, .busRequest, .grantLag, .busGrant, .opDone);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic endOfTest;
    if (badCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic flag(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dati <= d;
    for (k = 0; k < 20 && ack !== 1'h1; k++) tick(1);
    if (k == 20) begin
      badCount++;
      endOfTest;
    end
    rd = dato;
    cyc <= 1'h0;
    tick(1);
  endtask
  task automatic tRegs;
    wb(1'h0, DMART_CTRL_OFF, 32'h0);
    chk("ctrl", 32'h0, rd);
    wb(1'h0, 4'h6, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic tWait;
    grantLag <= 4'hf;
    wb(1'h1, DMART_WAIT_OFF, 32'h28);
    wb(1'h1, DMART_CTRL_OFF, 32'h2100);
    tick(25);
    flag("early", 1'h0, busRequest);
    tick(20);
    flag("counted", 1'h1, busRequest);
  endtask
  task automatic tIo;
    grantLag <= 4'h0;
    wb(1'h1, DMART_MASK_OFF, 32'h3);
    wb(1'h1, DMART_CTRL_OFF, 32'h1_3100);
    tick(900);
    flag("ioIdle", 1'h0, busRequest);
    flag("stallEarly", 1'h0, errorIrq);
    tick(150);
    flag("stallIrq", 1'h1, errorIrq);
    wb(1'h0, DMART_STAT_OFF, 32'h0);
    chk("stallFlag", 32'h1, rd & 32'h3);
    ioRequest <= 1'h1;
    tick(1);
    flag("ioReq", 1'h1, busRequest);
    tick(20);
    ioRequest <= 1'h0;
    wb(1'h1, DMART_STAT_OFF, 32'h3);
    wb(1'h1, DMART_CTRL_OFF, 32'h1_1100);
    tick(1100);
    flag("stallOff", 1'h0, errorIrq);
  endtask
  task automatic tGap;
    int c, n, k;
    grantLag <= 4'h2;
    wb(1'h1, DMART_WAIT_OFF, 32'h0);
    for (c = 0; c < 8; c++) begin
      wb(1'h1, DMART_CTRL_OFF, 32'h100 | (c << 13));
      for (k = 0; k < 300 && opDone !== 1'h1; k++) tick(1);
      if (k == 300) begin
        badCount++;
        endOfTest;
      end
      tick(1);
      for (n = 0; n < 2000 && busRequest !== 1'h1; n++) tick(1);
      chk("gap", (c == 0) ? 32'h0 : 32'h10 << (c - 1), 32'(n));
      if (badCount > 0) endOfTest;
    end
  endtask
  task automatic tIrq;
    wb(1'h1, DMART_CTRL_OFF, 32'h0);
    wb(1'h1, DMART_STAT_OFF, 32'h3);
    errorEnd <= 1'h1;
    tick(1);
    errorEnd <= 1'h0;
    wb(1'h0, DMART_STAT_OFF, 32'h0);
    chk("errFlag", 32'h2, rd & 32'h3);
    flag("irqOff", 1'h0, errorIrq);
    wb(1'h1, DMART_CTRL_OFF, 32'h1000);
    flag("irqOn", 1'h1, errorIrq);
    wb(1'h1, DMART_STAT_OFF, 32'h2);
    flag("irqClr", 1'h0, errorIrq);
    errorEnd <= 1'h1;
    tick(1);
    errorEnd <= 1'h0;
    tick(2);
    flag("irqErr", 1'h1, errorIrq);
  endtask
  initial begin
    tick(20);
    rst <= 1'h0;
    tRegs;
    tWait;
    tIo;
    tGap;
    tIrq;
    endOfTest;
  end
endmodule
